// ---- hw/lpc_pkg.sv ----
// Package: register map, field layout, counts and carrier structs of the error counters
package lpc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] LPC_IDX_CFG    = 8'h41;
  localparam logic [7:0] LPC_IDX_LCV_HI = 8'h42;
  localparam logic [7:0] LPC_IDX_LCV_LO = 8'h43;
  localparam logic [7:0] LPC_IDX_PCV_HI = 8'h44;
  localparam logic [7:0] LPC_IDX_PCV_LO = 8'h45;
  localparam logic [7:0] LPC_IDX_SEC_HI = 8'h46;
  localparam logic [7:0] LPC_IDX_SEC_LO = 8'h47;
  localparam logic [7:0] LPC_IDX_MODE   = 8'h50;

  // ----------------------------------------------------------------
  // counter_config fields
  // ----------------------------------------------------------------
  localparam int LPC_CFG_XZ_EN    = 0;
  localparam int LPC_CFG_MOS_SEL  = 1;
  localparam int LPC_CFG_FS_EN    = 2;
  localparam int LPC_CFG_E1_CV    = 3;
  localparam int LPC_CFG_MANUAL   = 4;
  localparam int LPC_CFG_SHORT    = 5;
  localparam int LPC_CFG_TRIGGER  = 6;
  localparam logic [7:0] LPC_CFG_WMASK = 8'h7F;
  localparam logic [7:0] LPC_CFG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // line_mode fields
  // ----------------------------------------------------------------
  localparam int LPC_MODE_E1   = 0;
  localparam int LPC_MODE_ESF  = 1;
  localparam int LPC_MODE_B8ZS = 2;
  localparam logic [2:0] LPC_MODE_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [13:0] LPC_FRAMES_1S       = 14'h1F40;
  localparam logic [13:0] LPC_FRAMES_T1_SHORT = 14'h014D;
  localparam logic [13:0] LPC_FRAMES_E1_SHORT = 14'h01F4;
  localparam logic [4:0]  LPC_ZRUN_PLAIN      = 5'h10;
  localparam logic [4:0]  LPC_ZRUN_B8ZS       = 5'h08;
  localparam logic [15:0] LPC_COUNT_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata;
  } lpc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } lpc_apb_rsp_t;

  typedef struct packed {
    logic bpv;
    logic cv;
    logic bit_valid;
    logic bit_mark;
    logic b8zs_codeword;
    logic ft_err;
    logic fs_err;
    logic crc6_err;
    logic fps_err;
    logic crc4_err;
    logic fas_err;
    logic mf_boundary;
    logic frame_pulse;
    logic receive_sync_lost;
    logic crc4_sync_lost;
    logic fas_search;
    logic cas_mf_search;
    logic crc4_mf_search;
  } lpc_line_ev_t;

endpackage : lpc_pkg

// ---- hw/lpc_apb_slave.sv ----
// APB slave front end: registered ready, read data and error response
`timescale 1ns/100ps
module lpc_apb_slave (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Bus
  input  wire lpc_pkg::lpc_apb_req_t apb_req,
  output lpc_pkg::lpc_apb_rsp_t      apb_rsp,
  // Register file side
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit,
  output logic                   wr_en
);

  typedef struct packed {
    lpc_pkg::lpc_apb_rsp_t rsp;
  } lpc_slv_state_t;

  lpc_slv_state_t st_r;
  lpc_slv_state_t st_nxt;

  // ----------------------------------------------------------------
  // Answer one cycle after setup, so pready rises in the access phase
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt             = st_r;
    st_nxt.rsp.pready  = 1'b0;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata  = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable) begin
      st_nxt.rsp.pready  = 1'b1;
      st_nxt.rsp.pslverr = ~rd_hit;
      st_nxt.rsp.prdata  = (rd_hit && !apb_req.pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp = st_r.rsp;
  // Errored writes are dropped
  assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                   st_r.rsp.pready && !st_r.rsp.pslverr;

endmodule : lpc_apb_slave

// ---- hw/lpc_interval_timer.sv ----
// Frame-counting timer for automatic counter updates
`timescale 1ns/100ps
module lpc_interval_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Control
  input  wire logic        hold,
  input  wire logic        frame_pulse,
  input  wire logic [13:0] limit,
  // Event
  output logic             tick
);

  typedef struct packed {
    logic [13:0] cnt;
    logic        tick;
  } lpc_tmr_state_t;

  lpc_tmr_state_t st_r;
  lpc_tmr_state_t st_nxt;

  // ----------------------------------------------------------------
  // Interval counting in received frames
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (hold) begin
      st_nxt.cnt = 14'h0000;
    end else if (frame_pulse) begin
      // Shortening the limit mid-interval must not strand the count above it
      if (st_r.cnt >= limit - 14'h0001) begin
        st_nxt.cnt  = 14'h0000;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : lpc_interval_timer

// ---- hw/lpc_counters.sv ----
// Line, path and sync error counters with APB access and latched count registers
//
// The APB slave port was decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - E1 line count: BPV or CV by select
// - Line count bytes at 42h and 43h
// - T1 ESF path count: CRC6 errors
// - T1 D4 path count: Ft, plus Fs when enabled
// - T1 path count halts on sync loss
// - E1 path count: each CRC-4 error
// - E1 path halts on FAS/CRC-4 loss
// - Path count bytes at 44h and 45h
// - T1 sync count: multiframes out of sync
// - T1 sync count: Ft or FPS errors
// - E1 sync count: FAS word errors
// - E1 no FAS count while searching
// - Sync count bytes at 46h and 47h
// - Auto update latches and restarts counters
// - Manual trigger rise latches next clock
// - Counters saturate, never roll over
// - T1 line count: BPV, optional zero runs
module lpc_counters (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Register bus
  input  wire lpc_pkg::lpc_apb_req_t apb_req,
  output lpc_pkg::lpc_apb_rsp_t      apb_rsp,
  // Receive framer and line decoder events
  input  wire lpc_pkg::lpc_line_ev_t line_ev
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cfg;
    logic [2:0]  mode;
    logic [15:0] lcv_run;
    logic [15:0] pcv_run;
    logic [15:0] sec_run;
    logic [15:0] lcv_held;
    logic [15:0] pcv_held;
    logic [15:0] sec_held;
    logic [4:0]  zero_run;
    logic        trig_prev;
  } lpc_cnt_state_t;

  lpc_cnt_state_t st_r;
  lpc_cnt_state_t st_nxt;

  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic        tick;
  logic [13:0] interval;
  logic [7:0]  bus_idx;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Restart wins over count but keeps an event of the same cycle
  function automatic logic [15:0] lpc_next_count(input logic [15:0] cnt,
                                                 input logic        inc,
                                                 input logic        restart);
    logic [15:0] res;
    res = cnt;
    if (restart) begin
      res = {15'h0000, inc};
    end else if (inc && cnt != lpc_pkg::LPC_COUNT_MAX) begin
      res = cnt + 16'h0001;
    end
    return res;
  endfunction : lpc_next_count

  function automatic logic [7:0] lpc_byte_of(input logic [15:0] val,
                                             input logic        high);
    return high ? val[15:8] : val[7:0];
  endfunction : lpc_byte_of

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  // Line code violations, never gated by sync loss
  function automatic logic lpc_line_inc(input lpc_pkg::lpc_line_ev_t evt,
                                        input logic [7:0]            cfg,
                                        input logic                  e1,
                                        input logic                  b8zs,
                                        input logic                  xz_event);
    logic inc;
    inc = 1'b0;
    if (e1) begin
      inc = cfg[lpc_pkg::LPC_CFG_E1_CV] ? evt.cv : evt.bpv;
    end else begin
      // Substituted codewords are the decoder's, not errors
      inc = (evt.bpv && !(b8zs && evt.b8zs_codeword)) ||
            (cfg[lpc_pkg::LPC_CFG_XZ_EN] && xz_event);
    end
    return inc;
  endfunction : lpc_line_inc

  // Path violations
  function automatic logic lpc_path_inc(input lpc_pkg::lpc_line_ev_t evt,
                                        input logic [7:0]            cfg,
                                        input logic                  e1,
                                        input logic                  esf);
    logic inc;
    inc = 1'b0;
    if (e1) begin
      // CAS multiframe loss alone does not gate
      inc = evt.crc4_err && !evt.receive_sync_lost &&
            !evt.crc4_sync_lost;
    end else if (!evt.receive_sync_lost) begin
      if (esf) begin
        inc = evt.crc6_err;
      end else begin
        inc = evt.ft_err ||
              (cfg[lpc_pkg::LPC_CFG_FS_EN] && evt.fs_err);
      end
    end
    return inc;
  endfunction : lpc_path_inc

  // Sync errors
  function automatic logic lpc_sync_inc(input lpc_pkg::lpc_line_ev_t evt,
                                        input logic [7:0]            cfg,
                                        input logic                  e1,
                                        input logic                  esf);
    logic inc;
    logic search;
    inc    = 1'b0;
    search = evt.fas_search || evt.cas_mf_search || evt.crc4_mf_search;
    if (e1) begin
      inc = evt.fas_err && !evt.receive_sync_lost;
      if (search) begin
        inc = 1'b0;
      end
    end else if (cfg[lpc_pkg::LPC_CFG_MOS_SEL]) begin
      // Counts whole multiframes spent out of sync
      inc = evt.mf_boundary && evt.receive_sync_lost;
    end else if (!evt.receive_sync_lost) begin
      inc = esf ? evt.fps_err : evt.ft_err;
    end
    return inc;
  endfunction : lpc_sync_inc

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  lpc_apb_slave u_slave (
    .clock   (clock),
    .arst_n  (arst_n),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .wr_en   (wr_en)
  );

  assign bus_idx = apb_req.paddr[9:2];

  // Reads only mux held counts, config and mode, so they never disturb counting
  always_comb begin
    rd_hit  = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0);
    rd_data = 32'h0000_0000;
    unique case (bus_idx)
      lpc_pkg::LPC_IDX_CFG: begin
        rd_data[7:0] = st_r.cfg;
      end
      lpc_pkg::LPC_IDX_MODE: begin
        rd_data[2:0] = st_r.mode;
      end
      lpc_pkg::LPC_IDX_LCV_HI: begin
        rd_data[7:0] = lpc_byte_of(st_r.lcv_held, 1'b1);
      end
      lpc_pkg::LPC_IDX_LCV_LO: begin
        rd_data[7:0] = lpc_byte_of(st_r.lcv_held, 1'b0);
      end
      lpc_pkg::LPC_IDX_PCV_HI: begin
        rd_data[7:0] = lpc_byte_of(st_r.pcv_held, 1'b1);
      end
      lpc_pkg::LPC_IDX_PCV_LO: begin
        rd_data[7:0] = lpc_byte_of(st_r.pcv_held, 1'b0);
      end
      lpc_pkg::LPC_IDX_SEC_HI: begin
        rd_data[7:0] = lpc_byte_of(st_r.sec_held, 1'b1);
      end
      lpc_pkg::LPC_IDX_SEC_LO: begin
        rd_data[7:0] = lpc_byte_of(st_r.sec_held, 1'b0);
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Update timer
  // ----------------------------------------------------------------
  always_comb begin
    unique case ({st_r.cfg[lpc_pkg::LPC_CFG_SHORT], st_r.mode[lpc_pkg::LPC_MODE_E1]})
      2'b10: begin
        interval = lpc_pkg::LPC_FRAMES_T1_SHORT;
      end
      2'b11: begin
        interval = lpc_pkg::LPC_FRAMES_E1_SHORT;
      end
      default: begin
        interval = lpc_pkg::LPC_FRAMES_1S;
      end
    endcase
  end

  lpc_interval_timer u_timer (
    .clock       (clock),
    .arst_n      (arst_n),
    .hold        (st_r.cfg[lpc_pkg::LPC_CFG_MANUAL]),
    .frame_pulse (line_ev.frame_pulse),
    .limit       (interval),
    .tick        (tick)
  );

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb begin
    logic        e1;
    logic        esf;
    logic        b8zs;
    logic        update;
    logic        xz_event;
    logic        lcv_inc;
    logic        pcv_inc;
    logic        sec_inc;
    logic [4:0]  zthr;

    e1        = st_r.mode[lpc_pkg::LPC_MODE_E1];
    esf       = st_r.mode[lpc_pkg::LPC_MODE_ESF];
    b8zs      = st_r.mode[lpc_pkg::LPC_MODE_B8ZS];
    update    = 1'b0;
    xz_event  = 1'b0;
    lcv_inc   = 1'b0;
    pcv_inc   = 1'b0;
    sec_inc   = 1'b0;
    zthr      = b8zs ? lpc_pkg::LPC_ZRUN_B8ZS : lpc_pkg::LPC_ZRUN_PLAIN;
    st_nxt    = st_r;

    // Register writes, low byte lane only
    if (wr_en && apb_req.pstrb[0]) begin
      if (bus_idx == lpc_pkg::LPC_IDX_CFG) begin
        st_nxt.cfg = apb_req.pwdata[7:0] & lpc_pkg::LPC_CFG_WMASK;
      end
      if (bus_idx == lpc_pkg::LPC_IDX_MODE) begin
        st_nxt.mode = apb_req.pwdata[2:0];
      end
    end

    // Update source: timer, or rising edge of the trigger bit
    st_nxt.trig_prev = st_r.cfg[lpc_pkg::LPC_CFG_TRIGGER];
    if (st_r.cfg[lpc_pkg::LPC_CFG_MANUAL]) begin
      update = st_r.cfg[lpc_pkg::LPC_CFG_TRIGGER] && !st_r.trig_prev;
    end else begin
      update = tick;
    end

    // Zero-run detector; one event per run, re-armed by a mark
    if (line_ev.bit_valid) begin
      if (line_ev.bit_mark) begin
        st_nxt.zero_run = 5'h00;
      end else if (st_r.zero_run < zthr) begin
        st_nxt.zero_run = st_r.zero_run + 5'h01;
        xz_event        = (st_r.zero_run == zthr - 5'h01);
      end
    end

    // Per-counter event selection by mode and config
    lcv_inc = lpc_line_inc(line_ev, st_r.cfg, e1, b8zs, xz_event);
    pcv_inc = lpc_path_inc(line_ev, st_r.cfg, e1, esf);
    sec_inc = lpc_sync_inc(line_ev, st_r.cfg, e1, esf);

    // Latch running counts and restart
    if (update) begin
      st_nxt.lcv_held = st_r.lcv_run;
      st_nxt.pcv_held = st_r.pcv_run;
      st_nxt.sec_held = st_r.sec_run;
    end
    st_nxt.lcv_run = lpc_next_count(st_r.lcv_run, lcv_inc, update);
    st_nxt.pcv_run = lpc_next_count(st_r.pcv_run, pcv_inc, update);
    st_nxt.sec_run = lpc_next_count(st_r.sec_run, sec_inc, update);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r      <= '0;
      st_r.cfg  <= lpc_pkg::LPC_CFG_RESET;
      st_r.mode <= lpc_pkg::LPC_MODE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : lpc_counters

// ---- test/lpc_counters_sva.sv ----
// Checker: bus timing and response rules of the error counters
`timescale 1ns/100ps
module lpc_counters_chk (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  arst_n,
  // Watched ports
  input wire lpc_pkg::lpc_apb_req_t apb_req,
  input wire lpc_pkg::lpc_apb_rsp_t apb_rsp,
  input wire lpc_pkg::lpc_line_ev_t line_ev
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [7:0] idx   = apb_req.paddr[9:2];
  wire logic       setup = apb_req.psel & ~apb_req.penable;
  wire logic       hit   = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0) &&
    (idx inside {[lpc_pkg::LPC_IDX_CFG:lpc_pkg::LPC_IDX_SEC_LO], lpc_pkg::LPC_IDX_MODE});

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  a_no_stray_ready: assert property (!setup |=> !apb_rsp.pready)
    else $error("ready without setup");
  a_unmapped_err: assert property (setup && !hit |=> apb_rsp.pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (setup && hit |=> !apb_rsp.pslverr)
    else $error("error on mapped address");
  a_err_data_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("data with error response");
  a_byte_wide: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper data bits set");
  a_cfg_top_zero: assert property (setup && !apb_req.pwrite &&
    idx == lpc_pkg::LPC_IDX_CFG |=> !apb_rsp.prdata[7])
    else $error("config bit 7 reads one");
endmodule : lpc_counters_chk

bind lpc_counters lpc_counters_chk u_lpc_counters_chk (.clock(clock), .arst_n(arst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .line_ev(line_ev));

// ---- test/lpc_line_model.sv ----
// Line partner: framer and decoder events of one receive line
`timescale 1ns/100ps
module lpc_line_model (
  // Clock
  input wire logic              clock,
  // Events
  output lpc_pkg::lpc_line_ev_t line_ev
);
  lpc_pkg::lpc_line_ev_t lvl = '0;

  initial line_ev = '0;

  // Levels change just after an edge, as a framer would
  task automatic level(input lpc_pkg::lpc_line_ev_t l);
    @(posedge clock);
    lvl = l;
    line_ev <= l;
  endtask : level

  // Gap 0 holds the event high for n cycles
  task automatic pulse(input lpc_pkg::lpc_line_ev_t e, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      line_ev <= lvl | e;
      repeat (gap) begin
        @(posedge clock);
        line_ev <= lvl;
      end
    end
    if (gap == 0) begin
      @(posedge clock);
      line_ev <= lvl;
    end
  endtask : pulse
endmodule : lpc_line_model

// ---- test/tb_lpc_counters.sv ----
// Testbench: error counters driven over the bus and from the line partner
`timescale 1ns/100ps
module tb_lpc_counters;
  logic                  clock;
  logic                  arst_n;
  lpc_pkg::lpc_apb_req_t apb_req;
  lpc_pkg::lpc_apb_rsp_t apb_rsp;
  lpc_pkg::lpc_line_ev_t line_ev;
  int                    err_total;
  int                    total_checks;
  localparam logic [7:0] CFG = lpc_pkg::LPC_IDX_CFG, MODE = lpc_pkg::LPC_IDX_MODE;
  localparam logic [7:0] LCV = lpc_pkg::LPC_IDX_LCV_HI, PCV = lpc_pkg::LPC_IDX_PCV_HI;
  localparam logic [7:0] SEC = lpc_pkg::LPC_IDX_SEC_HI;
  // Event bit positions in the carrier
  localparam int BPV = 17, CV = 16, BIT = 15, MARK = 14, B8CW = 13, FT = 12, FS = 11;
  localparam int CRC6 = 10, FPS = 9, CRC4 = 8, FAS = 7, MFB = 6, FRM = 5, RSL = 4;
  localparam int C4L = 3, FSRCH = 2, CASS = 1;

  lpc_counters u_lpc_counters (.clock(clock), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .line_ev(line_ev));
  lpc_line_model u_lpc_line_model (.clock(clock), .line_ev(line_ev));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic lpc_pkg::lpc_line_ev_t ev(input int k);
    ev = 18'h1 << k;
  endfunction : ev

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    apb_req.psel   <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr  <= {2'h0, idx, 2'h0};
    apb_req.pwdata <= {24'h0, wd};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    // Waits for pready; only the watchdog ends a wait that never sees it
    do begin
      @(posedge clock);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask : wr

  task automatic cnt(input logic [7:0] hi, output logic [15:0] c);
    logic [31:0] a;
    logic [31:0] b;
    logic        e;
    apb(1'b0, hi, 8'h00, a, e);
    apb(1'b0, hi + 8'h01, 8'h00, b, e);
    c = {a[7:0], b[7:0]};
  endtask : cnt

  // Manual update, then all three counts compared
  task automatic snap(input logic [7:0] base, input logic [15:0] l, p, s);
    logic [15:0] c;
    wr(CFG, base);
    wr(CFG, base | 8'h40);
    repeat (2) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, {16'h0, l});
    cnt(PCV, c);
    check({16'h0, c}, {16'h0, p});
    cnt(SEC, c);
    check({16'h0, c}, {16'h0, s});
  endtask : snap

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, LCV + 8'(i), 8'h00, d, e);
      check(d, 32'h0);
    end
    apb(1'b0, 8'h48, 8'h00, d, e);
    check({31'h0, e}, 32'h1);
    apb(1'b1, 8'h43, 8'hFF, d, e);
    check({31'h0, e}, 32'h0);
    apb(1'b0, 8'h43, 8'h00, d, e);
    check(d, 32'h0);
    wr(CFG, 8'h90);
    apb(1'b0, CFG, 8'h00, d, e);
    check(d, 32'h10);
  endtask : t_regs

  task automatic t_e1;
    wr(MODE, 8'h01);
    u_lpc_line_model.pulse(ev(BPV), 3, 1);
    u_lpc_line_model.pulse(ev(CV), 2, 1);
    u_lpc_line_model.pulse(ev(CRC4), 2, 1);
    u_lpc_line_model.pulse(ev(FAS), 1, 1);
    u_lpc_line_model.level(ev(C4L));
    u_lpc_line_model.pulse(ev(CRC4), 1, 1);
    u_lpc_line_model.level(ev(CASS));
    u_lpc_line_model.pulse(ev(CRC4) | ev(FAS), 1, 1);
    u_lpc_line_model.level(ev(FSRCH));
    u_lpc_line_model.pulse(ev(FAS), 1, 1);
    u_lpc_line_model.level(ev(RSL));
    u_lpc_line_model.pulse(ev(CRC4) | ev(FAS), 1, 1);
    u_lpc_line_model.level('0);
    snap(8'h10, 16'h3, 16'h3, 16'h1);
    wr(CFG, 8'h18);
    u_lpc_line_model.pulse(ev(BPV), 3, 1);
    u_lpc_line_model.pulse(ev(CV), 2, 1);
    snap(8'h18, 16'h2, 16'h0, 16'h0);
  endtask : t_e1

  task automatic t_t1;
    wr(MODE, 8'h00);
    u_lpc_line_model.pulse(ev(FT), 2, 1);
    u_lpc_line_model.pulse(ev(FS) | ev(CRC6) | ev(FPS), 1, 1);
    snap(8'h10, 16'h0, 16'h2, 16'h2);
    wr(CFG, 8'h14);
    u_lpc_line_model.pulse(ev(FT), 1, 1);
    u_lpc_line_model.pulse(ev(FS), 2, 1);
    u_lpc_line_model.level(ev(RSL));
    u_lpc_line_model.pulse(ev(FT) | ev(FS), 1, 1);
    u_lpc_line_model.level('0);
    snap(8'h14, 16'h0, 16'h3, 16'h1);
    wr(CFG, 8'h12);
    u_lpc_line_model.level(ev(RSL));
    u_lpc_line_model.pulse(ev(MFB), 3, 1);
    u_lpc_line_model.pulse(ev(FT), 1, 1);
    u_lpc_line_model.level('0);
    u_lpc_line_model.pulse(ev(MFB), 1, 1);
    snap(8'h12, 16'h0, 16'h0, 16'h3);
    wr(MODE, 8'h02);
    wr(CFG, 8'h14);
    u_lpc_line_model.pulse(ev(CRC6), 2, 1);
    u_lpc_line_model.pulse(ev(FT) | ev(FS) | ev(FPS), 1, 1);
    snap(8'h14, 16'h0, 16'h2, 16'h1);
  endtask : t_t1

  task automatic t_zeros;
    wr(MODE, 8'h00);
    wr(CFG, 8'h11);
    u_lpc_line_model.pulse(ev(BIT), 20, 1);
    u_lpc_line_model.pulse(ev(BIT) | ev(MARK), 1, 1);
    u_lpc_line_model.pulse(ev(BIT), 15, 1);
    u_lpc_line_model.pulse(ev(BPV), 1, 1);
    snap(8'h11, 16'h2, 16'h0, 16'h0);
    wr(MODE, 8'h04);
    u_lpc_line_model.pulse(ev(BIT) | ev(MARK), 1, 1);
    u_lpc_line_model.pulse(ev(BIT), 8, 1);
    u_lpc_line_model.pulse(ev(BPV) | ev(B8CW), 1, 1);
    u_lpc_line_model.pulse(ev(BPV), 1, 1);
    snap(8'h11, 16'h2, 16'h0, 16'h0);
  endtask : t_zeros

  // Short T1 interval: 333 frames
  task automatic t_auto;
    logic [15:0] c;
    wr(MODE, 8'h00);
    wr(CFG, 8'h20);
    u_lpc_line_model.pulse(ev(BPV), 4, 1);
    u_lpc_line_model.pulse(ev(FRM), 332, 1);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h2);
    u_lpc_line_model.pulse(ev(FRM), 1, 1);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h4);
    // Short E1 interval: 500 frames
    wr(MODE, 8'h01);
    u_lpc_line_model.pulse(ev(BPV), 3, 1);
    u_lpc_line_model.pulse(ev(FRM), 499, 1);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h4);
    u_lpc_line_model.pulse(ev(FRM), 1, 1);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h3);
    // One second: 8000 frames
    wr(CFG, 8'h00);
    u_lpc_line_model.pulse(ev(BPV), 5, 1);
    u_lpc_line_model.pulse(ev(FRM), 7999, 0);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h3);
    u_lpc_line_model.pulse(ev(FRM), 1, 1);
    repeat (3) @(posedge clock);
    cnt(LCV, c);
    check({16'h0, c}, 32'h5);
  endtask : t_auto

  task automatic t_sat;
    wr(CFG, 8'h10);
    u_lpc_line_model.pulse(ev(BPV), 65540, 0);
    snap(8'h10, 16'hFFFF, 16'h0, 16'h0);
  endtask : t_sat

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    err_total = 0;
    total_checks = 0;
    arst_n = 1'b0;
    apb_req = '{pstrb: 4'hF, default: '0};
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_regs;
    t_e1;
    t_t1;
    t_zeros;
    t_auto;
    t_sat;
    complete_run;
  end

  // Whole run is about 76000 cycles
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    complete_run;
  end
endmodule : tb_lpc_counters
